// ===== include/fsc_pkg.sv
// Package for the field set switch and contactor monitor: constants and state types.
// Assumes a 50 MHz system clock; all timing is counted in a millisecond tick.
// Notes on behaviour
// [RULE1] Fixed selection mode always monitors the default field set, select inputs ignored.
// [RULE2] With switchover monitoring, a transition outside the permitted table shuts outputs off.
// [RULE3] With switchover monitoring, switching to a deactivated field set shuts outputs off.
// [RULE4] Both switchover shutdowns only occur while switchover monitoring is enabled.
// [RULE5] Standby request on a standby-mode field set suspends monitoring, outputs held off.
// [RULE6] Controller leaves the covering field no earlier than hazard end minus changeover time.
// [RULE7] Contactor feedback monitoring is optional and checks both switch-on and switch-off.
// [RULE8] Feedback must be closed before each switch-on, otherwise outputs stay off.
// [RULE9] After switch-on release, feedback must open within 500 ms.
// [RULE10] After switch-off, feedback must close again within 500 ms.
// [RULE11] A failed feedback timing check returns outputs to off after the brief on.
// [RULE12] Feedback not at supply level while outputs off enters the fault lock.
// [RULE13] Feedback not open while outputs on enters the fault lock.
// [RULE14] Indication outputs carry configurable sources: fields, device, errors, warnings, diag.
// [RULE15] During switchover the old field set stays monitored for the switchover time.
// [RULE16] Occupied target field shuts off after 25 ms plus changeover plus response time.
// [RULE17] Timing uses a millisecond tick; fault lock persists until reset.
package fsc_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_MS_NS    = 1_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYCLES   = TICK_MS_NS / CLK_NS;
  localparam int unsigned FB_OPEN_MS    = 500;
  localparam int unsigned FB_CLOSE_MS   = 500;
  localparam int unsigned SYNC_MS       = 25;
  localparam int unsigned MS_W          = 16;

  // Indication source codes.
  localparam logic [2:0] SRC_PROT  = 3'h0;
  localparam logic [2:0] SRC_WARN  = 3'h1;
  localparam logic [2:0] SRC_RUN   = 3'h2;
  localparam logic [2:0] SRC_ERR   = 3'h3;
  localparam logic [2:0] SRC_WRN   = 3'h4;
  localparam logic [2:0] SRC_DIAG  = 3'h5;

  typedef enum logic [1:0] {
    FSC_OFF     = 2'b00,
    FSC_ON      = 2'b01,
    FSC_FBWAIT  = 2'b11,
    FSC_LOCK    = 2'b10
  } fsc_state_t;
endpackage

// ===== include/fsc_tick_if.sv
// Interface carrying the millisecond tick between the timebase and the monitor.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface fsc_tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface

// ===== verilog/fsc_ms_tick.sv
// Millisecond tick generator derived from the system clock.
// Assumes clock runs at the package rate; rst_n is synchronous.
`timescale 1ns/1ps
module fsc_ms_tick #(
  parameter int unsigned CYCLES = fsc_pkg::TICK_CYCLES
) (
  input  wire logic  clock,  // System clock.
  input  wire logic  rst_n,  // Synchronous reset, active low.
  fsc_tick_if.source tk      // One-cycle tick every millisecond.
);
  logic [31:0] cnt;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt     <= 32'h0;
      tk.tick <= 1'b0;
    end else if (cnt == CYCLES - 1) begin
      cnt     <= 32'h0;
      tk.tick <= 1'b1; // RULE17
    end else begin
      cnt     <= cnt + 32'h1;
      tk.tick <= 1'b0;
    end
  end
endmodule

// ===== verilog/fsc_monitor.sv
// Top of the field set switch and contactor monitor.
// Assumes synchronous select and feedback inputs; configuration is held stable by the system.
`timescale 1ns/1ps
module fsc_monitor #(
  parameter int unsigned NSETS       = 8,
  parameter int unsigned SEL_W       = 3,
  parameter int unsigned TICK_CYCLES = fsc_pkg::TICK_CYCLES,
  parameter int unsigned FB_OPEN_MS  = fsc_pkg::FB_OPEN_MS,
  parameter int unsigned FB_CLOSE_MS = fsc_pkg::FB_CLOSE_MS
) (
  input  wire logic               clock,                    // System clock, 50 MHz.
  input  wire logic               rst_n,                    // Synchronous reset, active low.
  input  wire logic               cfg_fixed_select,         // Fixed single field set mode.
  input  wire logic               cfg_switch_monitor,       // Switchover monitoring enable.
  input  wire logic [NSETS*NSETS-1:0] cfg_permit,           // Bit from*NSETS+to permits hop.
  input  wire logic [NSETS-1:0]   cfg_set_disabled,         // Field set marked deactivated.
  input  wire logic [NSETS-1:0]   cfg_set_standby,          // Field set uses standby mode.
  input  wire logic               cfg_feedback_enable,      // Contactor feedback monitoring.
  input  wire logic [7:0]         cfg_switch_ms,            // Changeover time in ms.
  input  wire logic [7:0]         cfg_response_ms,          // Response time in ms.
  input  wire logic [2:0]         cfg_ind_src_a,            // Source of indication A.
  input  wire logic [2:0]         cfg_ind_src_b,            // Source of indication B.
  input  wire logic [SEL_W-1:0]   field_select,             // Requested field set.
  input  wire logic               standby_request,          // Standby request input.
  input  wire logic [NSETS-1:0]   prot_field_occupied,      // Protective field per set occupied.
  input  wire logic [NSETS-1:0]   warn_field_occupied,      // Warning field per set occupied.
  input  wire logic               contactor_feedback_input, // High when feedback loop closed.
  output logic                    safety_switch_outputs,    // Safety outputs, high is on.
  output logic [SEL_W-1:0]        active_field_set,         // Field set being monitored.
  output logic                    fault_lock,               // Latched contactor fault.
  output logic                    switch_fault,             // Latched switchover fault.
  output logic                    standby_active,           // Standby suspends monitoring.
  output logic                    ind_a,                    // Indication output A.
  output logic                    ind_b                     // Indication output B.
);
  fsc_tick_if tk ();
  fsc_pkg::fsc_state_t state;
  fsc_pkg::fsc_state_t next_state;

  fsc_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tk    (tk.source)
  );

  function automatic logic permitted(input logic [NSETS*NSETS-1:0] tbl,
                                     input logic [SEL_W-1:0] from,
                                     input logic [SEL_W-1:0] to);
    int unsigned idx;
    idx = int'(from) * NSETS + int'(to);
    return tbl[idx];
  endfunction

  // True on the tick that completes a wait of limit milliseconds.
  function automatic logic ms_done(input logic [9:0] count, input logic [9:0] limit);
    return count + 10'h1 >= limit;
  endfunction

  localparam logic [SEL_W-1:0] DEFAULT_FIELD_SET = '0;

  logic [SEL_W-1:0] requested;
  logic [SEL_W-1:0] pending;
  logic             switching;
  logic [9:0]       sw_ms;
  logic [9:0]       occ_ms;
  logic [9:0]       fb_ms;
  logic             prot_now;
  logic             sw_violation;
  logic             standby_now;
  logic             want_on;
  logic             fb_check_fail;
  logic             fb_ready;
  logic             fb_clear;
  logic             fb_count;
  logic             next_outputs;
  logic             hop_new;
  logic             hop_forbidden;
  logic             target_disabled;
  logic [9:0]       occ_limit;
  logic [SEL_W-1:0] next_active;
  logic [SEL_W-1:0] next_pending;
  logic             next_switching;
  logic [9:0]       next_sw_ms;

  // The default field set is forced in fixed mode, whatever the select pins say.
  assign requested = cfg_fixed_select ? DEFAULT_FIELD_SET : field_select; // RULE1

  // Forbidden or deactivated targets only count while switchover monitoring is on.
  assign hop_new         = requested != pending;
  assign hop_forbidden   = !permitted(cfg_permit, active_field_set, requested); // RULE2
  assign target_disabled = cfg_set_disabled[requested]; // RULE3
  assign sw_violation    = cfg_switch_monitor && !cfg_fixed_select && hop_new && // RULE4
                           (hop_forbidden || target_disabled);

  assign standby_now = cfg_set_standby[active_field_set] && standby_request; // RULE5
  assign prot_now    = prot_field_occupied[active_field_set];

  // Switchover: the old set stays monitored until the changeover time has run out.
  // A new request restarts the wait, so a chattering select cannot cut it short.
  always_comb begin
    next_active    = active_field_set;
    next_pending   = pending;
    next_switching = switching;
    next_sw_ms     = sw_ms;
    if (hop_new) begin
      next_pending   = requested;
      next_switching = 1'b1;
      next_sw_ms     = 10'h0;
    end else if (switching && tk.tick) begin
      if (ms_done(sw_ms, {2'h0, cfg_switch_ms})) begin
        next_active    = pending; // RULE15
        next_switching = 1'b0;
      end
      next_sw_ms = sw_ms + 10'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_field_set <= '0;
      pending          <= '0;
      switching        <= 1'b0;
      sw_ms            <= 10'h0;
    end else begin
      active_field_set <= next_active;
      pending          <= next_pending;
      switching        <= next_switching;
      sw_ms            <= next_sw_ms;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      switch_fault <= 1'b0;
    end else if (sw_violation) begin
      switch_fault <= 1'b1; // RULE2
    end
  end

  // An occupied field trips the outputs only after sync, changeover and response times.
  always_ff @(posedge clock) begin
    if (!rst_n || !prot_now) begin
      occ_ms <= 10'h0;
    end else if (tk.tick && occ_ms != 10'h3ff) begin
      occ_ms <= occ_ms + 10'h1;
    end
  end

  assign occ_limit = 10'(fsc_pkg::SYNC_MS) + {2'h0, cfg_switch_ms} + // RULE16
                     {2'h0, cfg_response_ms};
  assign want_on   = !switch_fault && !standby_now && !(prot_now && occ_ms >= occ_limit);

  assign fb_check_fail = cfg_feedback_enable && tk.tick;
  assign fb_ready      = !cfg_feedback_enable || contactor_feedback_input;

  // Output and contactor feedback sequencing; the feedback timer is steered from here.
  always_comb begin
    next_state   = state;
    next_outputs = safety_switch_outputs;
    fb_clear     = 1'b0;
    fb_count     = 1'b0;
    case (state)
      fsc_pkg::FSC_OFF: begin
        if (fb_check_fail && !contactor_feedback_input) begin
          fb_count = 1'b1;
          if (ms_done(fb_ms, 10'(FB_CLOSE_MS))) begin
            next_state = fsc_pkg::FSC_LOCK; // RULE10
          end
        end else if (want_on && fb_ready) begin // RULE8
          next_state   = fsc_pkg::FSC_FBWAIT;
          next_outputs = 1'b1; // RULE7
          fb_clear     = 1'b1;
        end else if (fb_ready) begin
          fb_clear = 1'b1;
        end
      end
      fsc_pkg::FSC_FBWAIT: begin
        if (!want_on) begin
          next_state   = fsc_pkg::FSC_OFF;
          next_outputs = 1'b0;
          fb_clear     = 1'b1;
        end else if (!cfg_feedback_enable || !contactor_feedback_input) begin
          next_state = fsc_pkg::FSC_ON;
        end else if (tk.tick) begin
          fb_count = 1'b1;
          if (ms_done(fb_ms, 10'(FB_OPEN_MS))) begin
            next_state   = fsc_pkg::FSC_LOCK; // RULE9
            next_outputs = 1'b0; // RULE11
          end
        end
      end
      fsc_pkg::FSC_ON: begin
        if (cfg_feedback_enable && contactor_feedback_input) begin
          next_state   = fsc_pkg::FSC_LOCK; // RULE13
          next_outputs = 1'b0;
        end else if (!want_on) begin
          next_state   = fsc_pkg::FSC_OFF;
          next_outputs = 1'b0;
          fb_clear     = 1'b1;
        end
      end
      fsc_pkg::FSC_LOCK: begin
        // Only reset leaves the lock, so a stuck contactor cannot re-arm the outputs.
        next_outputs = 1'b0; // RULE17
      end
      default: begin
        next_state   = fsc_pkg::FSC_LOCK;
        next_outputs = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state                 <= fsc_pkg::FSC_OFF;
      safety_switch_outputs <= 1'b0;
    end else begin
      state                 <= next_state;
      safety_switch_outputs <= next_outputs;
    end
  end

  // One timer serves the open and the close check, since only one of them runs at a time.
  always_ff @(posedge clock) begin
    if (!rst_n || fb_clear) begin
      fb_ms <= 10'h0;
    end else if (fb_count) begin
      fb_ms <= fb_ms + 10'h1;
    end
  end

  // The lock covers a feedback still open or still closed when the grace time ran out, or closed while on.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_lock <= 1'b0;
    end else begin
      fault_lock <= fault_lock || (state == fsc_pkg::FSC_LOCK); // RULE12
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      standby_active <= 1'b0;
    end else begin
      standby_active <= standby_now; // RULE5
    end
  end

  function automatic logic ind_pick(input logic [2:0] src, input logic p, input logic w,
                                    input logic run, input logic err, input logic wrn,
                                    input logic dg);
    case (src)
      fsc_pkg::SRC_PROT: return p;
      fsc_pkg::SRC_WARN: return w;
      fsc_pkg::SRC_RUN:  return run;
      fsc_pkg::SRC_ERR:  return err;
      fsc_pkg::SRC_WRN:  return wrn;
      fsc_pkg::SRC_DIAG: return dg;
      default:           return 1'b0;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ind_a <= 1'b0;
      ind_b <= 1'b0;
    end else begin
      ind_a <= ind_pick(cfg_ind_src_a, prot_now, warn_field_occupied[active_field_set], // RULE14
                        safety_switch_outputs, fault_lock || switch_fault, standby_now,
                        switching);
      ind_b <= ind_pick(cfg_ind_src_b, prot_now, warn_field_occupied[active_field_set], // RULE14
                        safety_switch_outputs, fault_lock || switch_fault, standby_now,
                        switching);
    end
  end
endmodule

// ===== verification/fsc_contactor.sv
// Contactor model: a normally closed feedback contact that follows the safety outputs.
// Assumes the bench picks the fault mode; the armature delay is in clock cycles.
`timescale 1ns/1ps
module fsc_contactor #(
  parameter int DLY = 6
) (
  input  wire logic       clock, // System clock.
  input  wire logic       coil,  // Safety outputs driving the coil.
  input  wire logic [1:0] mode,  // 0 good, 1 welded shut, 2 open wire.
  output logic            fb     // High while the feedback loop is closed.
);
  int   cnt    = 0;
  logic pulled = 1'b0;
  // A slow armature makes the device's open and close timers do real work.
  always @(posedge clock) begin
    cnt <= (coil == pulled) ? 0 : cnt + 1;
    if (coil != pulled && cnt >= DLY)
      pulled <= coil;
  end
  assign fb = (mode == 2'h1) ? 1'b1 : (mode == 2'h2) ? 1'b0 : !pulled;
endmodule

// ===== verification/fsc_monitor_properties.sv
// Checker for the field set monitor, watching only its top ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module fsc_monitor_chk #(
  parameter int unsigned SEL_W = 3
) (
  input wire logic             clock,                    // Clock.
  input wire logic             rst_n,                    // Reset.
  input wire logic             cfg_fixed_select,         // Fixed mode.
  input wire logic             cfg_switch_monitor,       // Hop checks.
  input wire logic             cfg_feedback_enable,      // Feedback checks.
  input wire logic             contactor_feedback_input, // Loop closed.
  input wire logic             safety_switch_outputs,    // Outputs.
  input wire logic [SEL_W-1:0] active_field_set,         // Active set.
  input wire logic             fault_lock,               // Lock.
  input wire logic             switch_fault,             // Hop fault.
  input wire logic             standby_active            // Standby.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  lock_sticky_a: assert property (fault_lock |=> fault_lock)
    else $error("fault lock dropped");
  lock_off_a: assert property (fault_lock |=> !safety_switch_outputs)
    else $error("outputs on under lock");
  hop_off_a: assert property (switch_fault |=> !safety_switch_outputs)
    else $error("outputs on after hop fault");
  fb_closed_a: assert property ($rose(safety_switch_outputs) && cfg_feedback_enable
    |-> $past(contactor_feedback_input)) else $error("switch-on with open loop");
  fixed_set_a: assert property (cfg_fixed_select && $past(cfg_fixed_select)
    && active_field_set == '0 |=> active_field_set == '0) else $error("fixed set moved");
  standby_off_a: assert property (standby_active |-> !safety_switch_outputs)
    else $error("outputs on in standby");
  no_hop_a: assert property (!cfg_switch_monitor && !switch_fault |=> !switch_fault)
    else $error("hop fault with checks off");
  lock_cause_a: assert property ($rose(fault_lock) |-> $past(cfg_feedback_enable))
    else $error("lock without feedback checks");
  cover property ($rose(safety_switch_outputs));
  cover property ($rose(fault_lock));
  cover property ($rose(switch_fault));
endmodule
bind fsc_monitor fsc_monitor_chk #(.SEL_W(SEL_W)) chk (
  .clock                    (clock),
  .rst_n                    (rst_n),
  .cfg_fixed_select         (cfg_fixed_select),
  .cfg_switch_monitor       (cfg_switch_monitor),
  .cfg_feedback_enable      (cfg_feedback_enable),
  .contactor_feedback_input (contactor_feedback_input),
  .safety_switch_outputs    (safety_switch_outputs),
  .active_field_set         (active_field_set),
  .fault_lock               (fault_lock),
  .switch_fault             (switch_fault),
  .standby_active           (standby_active)
);

// ===== verification/testbench.sv
// Bench for the field set monitor: drives selection and config, checks outputs.
// Assumes the contactor model answers the outputs; tick scaled to 4 cycles.
`timescale 1ns/1ps
module testbench;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       fixed = 1'b0;
  logic       swmon = 1'b0;
  logic       fben  = 1'b1;
  logic [7:0] occ   = 8'h00;
  logic [7:0] wocc  = 8'h00;
  logic [2:0] sel   = 3'h0;
  logic [2:0] srca  = 3'h0;
  logic [2:0] srcb  = fsc_pkg::SRC_WRN;
  logic       stby  = 1'b0;
  logic [1:0] mode  = 2'h0;
  logic [7:0] dis   = 8'h00;
  logic [7:0] stbm  = 8'h00;
  logic       fb, outs, lock, sfault, sact, ia, ib;
  logic [2:0] aset;
  int         num_errors = 0;
  int         checked = 0;
  always #10 clock = ~clock;
  fsc_monitor #(.TICK_CYCLES(4), .FB_OPEN_MS(5), .FB_CLOSE_MS(5)) uut (
    .clock(clock), .rst_n(rst_n), .cfg_fixed_select(fixed), .cfg_switch_monitor(swmon),
    .cfg_permit(~(64'h1 << 10)), .cfg_set_disabled(dis), .cfg_set_standby(stbm),
    .cfg_feedback_enable(fben), .cfg_switch_ms(8'h02), .cfg_response_ms(8'h01),
    .cfg_ind_src_a(srca), .cfg_ind_src_b(srcb), .field_select(sel),
    .standby_request(stby), .prot_field_occupied(occ), .warn_field_occupied(wocc),
    .contactor_feedback_input(fb), .safety_switch_outputs(outs),
    .active_field_set(aset), .fault_lock(lock), .switch_fault(sfault),
    .standby_active(sact), .ind_a(ia), .ind_b(ib));
  fsc_contactor kon (.clock(clock), .coil(outs), .mode(mode), .fb(fb));
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_set(input string n, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_out(input logic lvl, input int bound);
    for (int i = 0; i < bound && outs !== lvl; i++)
      step(1);
    chk_bit("outputs", lvl, outs);
    if (outs !== lvl)
      end_of_test();
  endtask
  task automatic restart(input logic [1:0] m, input logic f, input logic e);
    rst_n = 1'b0;
    mode = m;
    fixed = f;
    fben = e;
    sel = 3'h0;
    step(16);
    rst_n = 1'b1;
  endtask
  // Hops are spaced wider than the changeover time, as the controller must.
  task automatic hop(input logic [2:0] to, input logic e);
    sel = to;
    step(16);
    chk_bit("switch_fault", e, sfault);
  endtask
  initial begin
    restart(2'h0, 1'b0, 1'b1);
    wait_out(1'b1, 40);
    chk_bit("fault_lock", 1'b0, lock);
    wocc = 8'hff;
    for (int s = 0; s < 6; s++) begin
      srca = s[2:0];
      step(2);
      chk_bit("ind_a", s == 1 || s == 2, ia);
    end
    wocc = 8'h00;
    sel = 3'h1;
    step(1);
    chk_set("active_set", 3'h0, aset);
    step(15);
    chk_set("active_set", 3'h1, aset);
    hop(3'h2, 1'b0);
    stby = 1'b1;
    step(4);
    chk_bit("outputs", 1'b1, outs);
    chk_bit("standby_active", 1'b0, sact);
    stbm = 8'h04;
    wait_out(1'b0, 8);
    step(1);
    chk_bit("standby_active", 1'b1, sact);
    chk_bit("ind_b", 1'b1, ib);
    stby = 1'b0;
    wait_out(1'b1, 40);
    occ = 8'hff;
    step(100);
    chk_bit("outputs", 1'b1, outs);
    wait_out(1'b0, 30);
    mode = 2'h2;
    occ = 8'h00;
    step(40);
    chk_bit("fault_lock", 1'b1, lock);
    chk_bit("outputs", 1'b0, outs);
    srcb = fsc_pkg::SRC_ERR;
    step(2);
    chk_bit("ind_b", 1'b1, ib);
    restart(2'h1, 1'b0, 1'b1);
    wait_out(1'b1, 40);
    wait_out(1'b0, 40);
    step(1);
    chk_bit("fault_lock", 1'b1, lock);
    restart(2'h2, 1'b0, 1'b1);
    step(40);
    chk_bit("outputs", 1'b0, outs);
    chk_bit("fault_lock", 1'b1, lock);
    restart(2'h2, 1'b0, 1'b0);
    wait_out(1'b1, 40);
    step(40);
    chk_bit("fault_lock", 1'b0, lock);
    swmon = 1'b1;
    restart(2'h0, 1'b0, 1'b1);
    hop(3'h3, 1'b0);
    hop(3'h1, 1'b0);
    hop(3'h2, 1'b1);
    chk_bit("outputs", 1'b0, outs);
    dis = 8'h08;
    restart(2'h0, 1'b0, 1'b1);
    hop(3'h3, 1'b1);
    restart(2'h0, 1'b1, 1'b1);
    hop(3'h3, 1'b0);
    chk_set("active_set", 3'h0, aset);
    end_of_test();
  end
endmodule
